// File: design/rmf_top.v
// Reading meter path: filters, detector, reading rate, AHB-Lite registers
`timescale 1ns/100ps
`include "rmf_defs.vh"

// Overview of operation
// - Highpass offers near-flat setting or 22, 100, 400 Hz corners on both channels.
// - Highpass applies in every function except bandpass and crosstalk, where bypassed.
// - Filters sit only in reading paths; level and counter inputs stay unfiltered.
// - 22 Hz and 100 Hz highpass use four poles, 24 dB per octave.
// - 400 Hz is four-pole in THD+N, ten-pole sharp in amplitude and ratio.
// - Ten-pole 400 Hz highpass rejects below about 220 Hz, passes above 400 Hz.
// - Fixed corners are independent of sample rate; flat corner runs about 3 Hz to 10 Hz.
// - Lowpass offers half sample rate, 20 kHz or 15 kHz, except bandpass, crosstalk.
// - 20 kHz and 15 kHz lowpass use six poles.
// - Lowpass is rate independent above 44 kHz, degrades to half-rate setting at or below twice its corner.
// - Reading rate Auto or 4 to 256 per second sets every meter interval.
// - RMS and quasi-peak interval equals one period of the reading rate.
// - Fast RMS period is a minimum, extended to next rising zero crossing, at most four periods.
// - Auto picks fastest accurate rate from signal frequency and bandpass use.
// - Detectors RMS, fast RMS, quasi-peak; level meters use RMS under quasi-peak.
// - Quasi-peak detector gives a fast-attack slow-decay peak response.
// - In amplitude, ratio and THD+N the filter field selects weighting.
// - In bandpass the filter field picks fundamental or 2nd to 5th harmonic.
// - Crosstalk forces narrow selection; IMD and phase ignore the field.
// - Harmonic choices keep 5.2 percent bandwidth, multiply steering frequency.
module rmf_top #(
  parameter DW = 24,
  parameter FW = 20
) (
  input  wire                 hclk,
  input  wire                 hresetn,
  input  wire                 hsel,
  input  wire [31:0]          haddr,
  input  wire [1:0]           htrans,
  input  wire                 hwrite,
  input  wire [2:0]           hsize,
  input  wire [31:0]          hwdata,
  input  wire                 hready,
  output reg  [31:0]          hrdata,
  output reg                  hreadyout,
  output reg                  hresp,
  input  wire                 smp_valid,
  input  wire signed [DW-1:0] smp_a,
  input  wire signed [DW-1:0] smp_b,
  input  wire [FW-1:0]        meas_freq_hz,
  input  wire [FW-1:0]        steer_freq_hz,
  output reg  [31:0]          res_a,
  output reg  [31:0]          res_b,
  output reg                  res_valid,
  output reg  [1:0]           level_det_sel,
  output reg  [2:0]           weight_sel,
  output reg  [FW+2:0]        bp_center_hz,
  output reg  [15:0]          bp_bw_permille
);

  localparam SW = DW + 8;
  localparam NHP = `RMF_POLES_ELL;
  localparam NLP = `RMF_POLES_LP;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Largest shift k with 6*fc*2^k <= fs: one-pole coefficient near 2*pi*fc/fs
  function [4:0] coef_shift;
    input [17:0] fs;
    input [15:0] fc;
    integer k;
    reg [47:0] t;
    begin
      coef_shift = 5'h01;
      for (k = 1; k < 24; k = k + 1) begin
        t = ({32'h0, fc} * 48'd6) << k;
        if (t <= {30'h0, fs})
          coef_shift = k[4:0];
      end
    end
  endfunction

  // Floor of log2, used to normalise the square sum
  function [4:0] flog2;
    input [FW+1:0] v;
    integer k;
    begin
      flog2 = 5'h00;
      for (k = 0; k < FW + 2; k = k + 1) begin
        if (v[k])
          flog2 = k[4:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Software registers and active copies
  // ----------------------------------------------------------------
  reg  [31:0]       ctrl_q;
  reg  [17:0]       fs_q;
  reg  [2:0]        fn_q;
  reg  [1:0]        hp_q;
  reg  [1:0]        lp_q;
  reg  [2:0]        fsel_q;
  reg  [1:0]        det_q;
  reg  [2:0]        ridx_q;
  reg  [17:0]       fsa_q;
  reg               dph_q;
  reg               dwr_q;
  reg  [7:0]        dadr_q;
  reg  [31:0]       rd_d;

  // Filter and detector state
  reg  signed [SW-1:0] hp_s [0:2*NHP-1];
  reg  signed [SW-1:0] lp_s [0:2*NLP-1];
  reg  signed [SW-1:0] hp_d [0:2*NHP-1];
  reg  signed [SW-1:0] lp_d [0:2*NLP-1];
  reg  signed [SW-1:0] y_d  [0:1];
  reg  signed [SW-1:0] pk_q [0:1];
  reg  [63:0]          acc_q [0:1];
  reg  [FW+1:0]        cnt_q;
  reg                  neg_a_q;

  // ----------------------------------------------------------------
  // Stage configuration from the active settings
  // ----------------------------------------------------------------
  wire       bp_xt   = (fn_q == `RMF_FN_BANDPASS) || (fn_q == `RMF_FN_XTALK);
  wire       thdn    = (fn_q == `RMF_FN_THDN_A) || (fn_q == `RMF_FN_THDN_R);
  wire       ampl_rt = (fn_q == `RMF_FN_AMPL) || (fn_q == `RMF_FN_RATIO);
  reg  [3:0] hp_n;
  reg  [4:0] hp_k;
  reg  [3:0] lp_n;
  reg  [4:0] lp_k;

  // Pole counts and coefficients; shifts follow fs so corners stay put
  always @* begin
    hp_n = 4'h0;
    hp_k = coef_shift(fsa_q, 16'd`RMF_HP22_HZ);
    case (hp_q)
      `RMF_HP_FLAT: begin
        hp_n = 4'h1;
        hp_k = coef_shift(fsa_q, (fsa_q < `RMF_FLAT_SPLIT) ?
                          16'd`RMF_FLAT_LO_HZ : 16'd`RMF_FLAT_HI_HZ);
      end
      `RMF_HP_22: begin
        hp_n = 4'd`RMF_POLES_STD;
        hp_k = coef_shift(fsa_q, 16'd`RMF_HP22_HZ);
      end
      `RMF_HP_100: begin
        hp_n = 4'd`RMF_POLES_STD;
        hp_k = coef_shift(fsa_q, 16'd`RMF_HP100_HZ);
      end
      default: begin
        hp_n = ampl_rt ? 4'd`RMF_POLES_ELL : 4'd`RMF_POLES_STD;
        hp_k = coef_shift(fsa_q, 16'd`RMF_HP400_HZ);
      end
    endcase
    if (bp_xt)
      hp_n = 4'h0;
    lp_n = 4'h0;
    lp_k = coef_shift(fsa_q, 16'd`RMF_LP20_HZ);
    case (lp_q)
      `RMF_LP_20K: begin
        lp_n = 4'd`RMF_POLES_LP;
        lp_k = coef_shift(fsa_q, 16'd`RMF_LP20_HZ);
        if (fsa_q <= 2 * `RMF_LP20_HZ)
          lp_n = 4'h0;
      end
      `RMF_LP_15K: begin
        lp_n = 4'd`RMF_POLES_LP;
        lp_k = coef_shift(fsa_q, 16'd`RMF_LP15_HZ);
        if (fsa_q <= 2 * `RMF_LP15_HZ)
          lp_n = 4'h0;
      end
      default: lp_n = 4'h0;
    endcase
    // Above the independence rate a fixed step is kept, at most one octave
    if (fsa_q > `RMF_LP_INDEP_FS && lp_k > 5'h1)
      lp_k = lp_k - 5'h1;
    if (bp_xt)
      lp_n = 4'h0;
  end

  // ----------------------------------------------------------------
  // Filter datapath: highpass, lowpass, weighting, per channel
  // ----------------------------------------------------------------
  // Cascades of first-order sections; the weighting stage passes through
  // since its shapes live outside this block. Only the reading path is fed.
  reg signed [SW-1:0] v;
  reg signed [SW-1:0] s;
  integer c;
  integer i;
  always @* begin
    v = {SW{1'b0}};
    s = {SW{1'b0}};
    for (c = 0; c < 2; c = c + 1) begin
      v = (c == 0) ? {{(SW-DW){smp_a[DW-1]}}, smp_a} : {{(SW-DW){smp_b[DW-1]}}, smp_b};
      for (i = 0; i < NHP; i = i + 1) begin
        hp_d[c*NHP+i] = hp_s[c*NHP+i];
        if (i < hp_n) begin
          s = hp_s[c*NHP+i] + ((v - hp_s[c*NHP+i]) >>> hp_k);
          hp_d[c*NHP+i] = s;
          v = v - s;
        end
      end
      for (i = 0; i < NLP; i = i + 1) begin
        lp_d[c*NLP+i] = lp_s[c*NLP+i];
        if (i < lp_n) begin
          s = lp_s[c*NLP+i] + ((v - lp_s[c*NLP+i]) >>> lp_k);
          lp_d[c*NLP+i] = s;
          v = s;
        end
      end
      y_d[c] = v;
    end
  end

  // ----------------------------------------------------------------
  // Reading rate and interval length
  // ----------------------------------------------------------------
  // Auto judges the bandpass use of the function about to take effect
  wire          bp_nxt = (ctrl_q[`RMF_FUNC_LSB+:3] == `RMF_FN_BANDPASS) ||
                         (ctrl_q[`RMF_FUNC_LSB+:3] == `RMF_FN_XTALK);
  reg  [2:0]    auto_idx;
  reg  [2:0]    nxt_idx;
  reg  [FW+1:0] len;
  integer r;
  always @* begin
    auto_idx = 3'h0;
    for (r = 0; r < 7; r = r + 1) begin
      if ({4'h0, meas_freq_hz} >= ((bp_nxt ? `RMF_AUTO_CYC_BP : `RMF_AUTO_CYC) *
                                   (`RMF_RATE_BASE << r)))
        auto_idx = r[2:0];
    end
    nxt_idx = (ctrl_q[`RMF_RATE_LSB+:3] == `RMF_RATE_AUTO) ? auto_idx :
              ctrl_q[`RMF_RATE_LSB+:3] - 3'h1;
    len = {{(FW-16){1'b0}}, (fsa_q >> 2) >> ridx_q};
    if (len == {(FW+2){1'b0}})
      len = {{(FW+1){1'b0}}, 1'b1};
  end

  wire cnt_full = (cnt_q + 1'b1) >= len;
  wire cross_a  = neg_a_q && !y_d[0][SW-1];
  wire cap      = (cnt_q + 1'b1) >= (len << `RMF_FAST_CAP);
  wire iv_end   = smp_valid && ((det_q == `RMF_DET_FAST) ?
                  ((cnt_full && cross_a) || cap) : cnt_full);

  // ----------------------------------------------------------------
  // Detector state and interval sequencing
  // ----------------------------------------------------------------
  reg [63:0]       sq;
  reg signed [SW-1:0] mag;
  reg signed [SW-1:0] pk_n [0:1];
  reg [63:0]       acc_n [0:1];
  integer d;
  always @* begin
    sq  = 64'h0;
    mag = {SW{1'b0}};
    for (d = 0; d < 2; d = d + 1) begin
      mag = y_d[d][SW-1] ? -y_d[d] : y_d[d];
      sq  = $signed(y_d[d]) * $signed(y_d[d]);
      acc_n[d] = acc_q[d] + sq;
      // Fast attack, slow decay peak follower
      if (mag > pk_q[d])
        pk_n[d] = pk_q[d] + ((mag - pk_q[d]) >>> `RMF_QP_ATTACK);
      else
        pk_n[d] = pk_q[d] - (pk_q[d] >>> `RMF_QP_DECAY);
    end
  end

  wire [4:0] lg = flog2(cnt_q + 1'b1);
  wire [63:0] ms_a = acc_n[0] >> lg;
  wire [63:0] ms_b = acc_n[1] >> lg;

  // Filter states, detector sums and active settings
  integer n;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (n = 0; n < 2*NHP; n = n + 1)
        hp_s[n] <= {SW{1'b0}};
      for (n = 0; n < 2*NLP; n = n + 1)
        lp_s[n] <= {SW{1'b0}};
      for (n = 0; n < 2; n = n + 1) begin
        acc_q[n] <= 64'h0;
        pk_q[n]  <= {SW{1'b0}};
      end
      cnt_q     <= {(FW+2){1'b0}};
      neg_a_q   <= 1'b0;
      fn_q      <= 3'h0;
      hp_q      <= 2'h0;
      lp_q      <= 2'h0;
      fsel_q    <= 3'h0;
      det_q     <= 2'h0;
      ridx_q    <= 3'h0;
      fsa_q     <= `RMF_FS_RST;
      res_a     <= 32'h0;
      res_b     <= 32'h0;
      res_valid <= 1'b0;
    end else begin
      res_valid <= 1'b0;
      if (smp_valid) begin
        for (n = 0; n < 2*NHP; n = n + 1)
          hp_s[n] <= hp_d[n];
        for (n = 0; n < 2*NLP; n = n + 1)
          lp_s[n] <= lp_d[n];
        neg_a_q <= y_d[0][SW-1];
        if (iv_end) begin
          res_valid <= 1'b1;
          res_a     <= (det_q == `RMF_DET_QPK) ? pk_n[0] : ms_a[47:16];
          res_b     <= (det_q == `RMF_DET_QPK) ? pk_n[1] : ms_b[47:16];
          cnt_q     <= {(FW+2){1'b0}};
          acc_q[0]  <= 64'h0;
          acc_q[1]  <= 64'h0;
          // New settings only at an interval boundary
          fn_q      <= ctrl_q[`RMF_FUNC_LSB+:3];
          hp_q      <= ctrl_q[`RMF_HP_LSB+:2];
          lp_q      <= ctrl_q[`RMF_LP_LSB+:2];
          fsel_q    <= ctrl_q[`RMF_FSEL_LSB+:3];
          det_q     <= ctrl_q[`RMF_DET_LSB+:2];
          ridx_q    <= nxt_idx;
          fsa_q     <= fs_q;
        end else begin
          cnt_q    <= cnt_q + 1'b1;
          acc_q[0] <= acc_n[0];
          acc_q[1] <= acc_n[1];
        end
        pk_q[0] <= pk_n[0];
        pk_q[1] <= pk_n[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Filter field decode and level meter detector
  // ----------------------------------------------------------------
  reg [2:0] fsel_eff;
  always @* begin
    case (fn_q)
      `RMF_FN_XTALK:    fsel_eff = `RMF_FSEL_NARROW;
      `RMF_FN_IMD:      fsel_eff = 3'h0;
      `RMF_FN_PHASE:    fsel_eff = 3'h0;
      `RMF_FN_BANDPASS: fsel_eff = (fsel_q > 3'h4) ? 3'h4 : fsel_q;
      default:          fsel_eff = fsel_q;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_det_sel  <= 2'h0;
      weight_sel     <= 3'h0;
      bp_center_hz   <= {(FW+3){1'b0}};
      bp_bw_permille <= 16'h0;
    end else begin
      level_det_sel  <= (det_q == `RMF_DET_QPK) ? `RMF_DET_RMS : det_q;
      weight_sel     <= (ampl_rt || thdn) ? fsel_eff : 3'h0;
      bp_center_hz   <= bp_xt ? steer_freq_hz * ({2'h0, fsel_eff} + 3'h1) :
                        {(FW+3){1'b0}};
      bp_bw_permille <= bp_xt ? `RMF_BP_BW_PM : 16'h0;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------------
  // Read data is formed in the address phase so hrdata is a flop output
  always @* begin
    case (haddr[7:0])
      `RMF_OFS_CTRL:   rd_d = ctrl_q;
      `RMF_OFS_FS:     rd_d = {14'h0, fs_q};
      `RMF_OFS_STATUS: rd_d = {9'h0, ridx_q, 2'h0, det_q, 1'b0, fsel_eff,
                               2'h0, lp_q, 2'h0, hp_q, 1'b0, fn_q};
      `RMF_OFS_RES_A:  rd_d = res_a;
      `RMF_OFS_RES_B:  rd_d = res_b;
      `RMF_OFS_BPFREQ: rd_d = {{(29-FW){1'b0}}, bp_center_hz};
      default:         rd_d = 32'h0;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q     <= 1'b0;
      dwr_q     <= 1'b0;
      dadr_q    <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      ctrl_q    <= `RMF_CTRL_RST;
      fs_q      <= `RMF_FS_RST;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dph_q     <= hsel && hready && htrans[1];
      if (hsel && hready && htrans[1]) begin
        dwr_q  <= hwrite;
        dadr_q <= haddr[7:0];
        hrdata <= hwrite ? 32'h0 : rd_d;
      end
      // Writes land in the data phase; read-only offsets ignore them
      if (dph_q && dwr_q) begin
        if (dadr_q == `RMF_OFS_CTRL)
          ctrl_q <= hwdata;
        if (dadr_q == `RMF_OFS_FS)
          fs_q <= hwdata[17:0];
      end
    end
  end

endmodule

// File: inc/rmf_defs.vh
// Constants for the reading meter filter and detector block
`ifndef RMF_DEFS_VH
`define RMF_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RMF_OFS_CTRL     8'h00
`define RMF_OFS_FS       8'h04
`define RMF_OFS_STATUS   8'h08
`define RMF_OFS_RES_A    8'h0c
`define RMF_OFS_RES_B    8'h10
`define RMF_OFS_BPFREQ   8'h14

// ----------------------------------------------------------------
// Control field positions and reset values
// ----------------------------------------------------------------
`define RMF_FUNC_LSB     0
`define RMF_HP_LSB       4
`define RMF_LP_LSB       8
`define RMF_FSEL_LSB     12
`define RMF_DET_LSB      16
`define RMF_RATE_LSB     20
`define RMF_CTRL_RST     32'h0000_0000
`define RMF_FS_RST       18'h0bb80

// ----------------------------------------------------------------
// Meter functions
// ----------------------------------------------------------------
`define RMF_FN_AMPL      3'h0
`define RMF_FN_RATIO     3'h1
`define RMF_FN_THDN_A    3'h2
`define RMF_FN_THDN_R    3'h3
`define RMF_FN_BANDPASS  3'h4
`define RMF_FN_XTALK     3'h5
`define RMF_FN_IMD       3'h6
`define RMF_FN_PHASE     3'h7

// ----------------------------------------------------------------
// Filter selections, corners in Hz
// ----------------------------------------------------------------
`define RMF_HP_FLAT      2'h0
`define RMF_HP_22        2'h1
`define RMF_HP_100       2'h2
`define RMF_HP_400       2'h3
`define RMF_LP_HALF      2'h0
`define RMF_LP_20K       2'h1
`define RMF_LP_15K       2'h2
`define RMF_HP22_HZ      22
`define RMF_HP100_HZ     100
`define RMF_HP400_HZ     400
`define RMF_FLAT_LO_HZ   3
`define RMF_FLAT_HI_HZ   10
`define RMF_FLAT_SPLIT   48000
`define RMF_LP20_HZ      20000
`define RMF_LP15_HZ      15000
`define RMF_LP_INDEP_FS  44000
`define RMF_POLES_STD    4
`define RMF_POLES_ELL    10
`define RMF_POLES_LP     6
`define RMF_FSEL_NARROW  3'h0
`define RMF_BP_BW_PM     16'h0034

// ----------------------------------------------------------------
// Detectors and reading rates
// ----------------------------------------------------------------
`define RMF_DET_RMS      2'h0
`define RMF_DET_FAST     2'h1
`define RMF_DET_QPK      2'h2
`define RMF_RATE_AUTO    3'h0
`define RMF_RATE_BASE    4
`define RMF_AUTO_CYC     4
`define RMF_AUTO_CYC_BP  16
`define RMF_QP_ATTACK    4
`define RMF_QP_DECAY     12
`define RMF_FAST_CAP     2

`endif

// File: verif/reading_meter_filter_detector_tb.sv
// Self-checking bench for the reading meter filter and detector
`timescale 1ns/100ps
`include "rmf_defs.vh"
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module reading_meter_filter_detector_tb;
  localparam int FS  = 64;
  localparam int TMO = 30000;
  logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]        haddr, hwdata, hrdata, res_a, res_b, rd, seed;
  logic [1:0]         htrans, level_det_sel, mode;
  logic [2:0]         hsize, weight_sel;
  logic               smp_valid, res_valid;
  logic signed [23:0] smp_a, smp_b;
  logic [19:0]        meas_freq_hz, steer_freq_hz;
  logic [22:0]        bp_center_hz;
  logic [15:0]        bp_bw_permille;
  int                 miscompares, n_checks, cyc, cnt_q, len_q, f, s;

  assign hready = hreadyout;

  rmf_top #(.DW(24), .FW(20)) rmf_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .smp_valid(smp_valid), .smp_a(smp_a),
    .smp_b(smp_b), .meas_freq_hz(meas_freq_hz), .steer_freq_hz(steer_freq_hz),
    .res_a(res_a), .res_b(res_b), .res_valid(res_valid), .level_det_sel(level_det_sel),
    .weight_sel(weight_sel), .bp_center_hz(bp_center_hz), .bp_bw_permille(bp_bw_permille));

  rmf_stream_src #(.DW(24)) rmf_stream_src_inst (
    .clk(hclk), .rstn(hresetn), .mode(mode), .smp_valid(smp_valid), .smp_a(smp_a),
    .smp_b(smp_b));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Strobes per interval, latched when each result appears
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (res_valid === 1'b1) begin
      len_q <= cnt_q;
      cnt_q <= int'(smp_valid === 1'b1);
    end else if (smp_valid === 1'b1) begin
      cnt_q <= cnt_q + 1;
    end
    // Timeout last, so nothing runs after the run ends
    if (cyc == TMO) begin
      miscompares++;
      report_and_stop;
    end
  end

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wait_res;
    @(posedge hclk);
    while (res_valid !== 1'b1) @(posedge hclk);
  endtask

  // Settings only land at an interval end, so let two pass, measure a third
  task automatic apply(input logic [31:0] ctrl);
    bus(1'b1, `RMF_OFS_CTRL, ctrl);
    repeat (3) wait_res;
    repeat (2) @(posedge hclk);
  endtask

  function automatic int exp_len(input int idx);
    int l;
    l = (FS >> 2) >> idx;
    return (l < 1) ? 1 : l;
  endfunction

  function automatic int auto_idx(input int mf, input int c);
    int k;
    k = 0;
    for (int i = 1; i < 7; i++) if (mf >= c * (4 << i)) k = i;
    return k;
  endfunction

  function automatic logic [22:0] exp_center(input int fn, input int fs_, input int st);
    if (fn == 4) return 23'(st * (((fs_ > 4) ? 4 : fs_) + 1));
    if (fn == 5) return 23'(st);
    return 23'h0;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mode = 2'h1;
    meas_freq_hz = 20'd100;
    steer_freq_hz = 20'd1000;
    {miscompares, n_checks, cyc, cnt_q, len_q} = '0;
    seed = $urandom(92);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, unmapped and read-only places
    bus(1'b0, `RMF_OFS_CTRL, 32'h0);
    chk(rd, `RMF_CTRL_RST);
    bus(1'b0, `RMF_OFS_FS, 32'h0);
    chk(rd, {14'h0, `RMF_FS_RST});
    bus(1'b1, 8'h40, $urandom);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `RMF_OFS_STATUS, 32'hffff_ffff);
    bus(1'b0, `RMF_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    // Small sample rate for short intervals; 4/s as for noise work
    bus(1'b1, `RMF_OFS_FS, FS);
    apply(32'h1 << `RMF_RATE_LSB);
    chk(len_q, exp_len(0));
    // Every fixed rate, slow source on even codes
    for (int r = 1; r < 8; r++) begin
      mode <= (r % 2) ? 2'h1 : 2'h2;
      apply(32'(r) << `RMF_RATE_LSB);
      chk(len_q, exp_len(r - 1));
    end
    mode <= 2'h1;
    // New settings wait for the interval end
    apply(32'h1 << `RMF_RATE_LSB);
    wait_res;
    bus(1'b1, `RMF_OFS_CTRL, (32'h1 << `RMF_RATE_LSB) | 32'(`RMF_FN_BANDPASS));
    bus(1'b0, `RMF_OFS_STATUS, 32'h0);
    chk(rd[2:0], `RMF_FN_AMPL);
    chk(bp_bw_permille, 32'h0);
    repeat (2) wait_res;
    repeat (2) @(posedge hclk);
    bus(1'b0, `RMF_OFS_STATUS, 32'h0);
    chk(rd[2:0], `RMF_FN_BANDPASS);
    // Detector kinds and what the level meters copy
    for (int d = 0; d < 3; d++) begin
      apply((32'h1 << `RMF_RATE_LSB) | (32'(d) << `RMF_DET_LSB));
      chk(level_det_sel, (d == 1) ? 32'h1 : 32'h0);
      chk(res_a != 32'h0, 32'h1);
      chk(res_b, 32'h0);
      if (d == 1) chk(len_q >= exp_len(0) && len_q <= 4 * exp_len(0), 32'h1);
      else chk(len_q, exp_len(0));
    end
    // Auto rate with and without the bandpass in use
    for (int i = 0; i < 4; i++) begin
      meas_freq_hz <= i[1] ? 20'd5000 : 20'd100;
      apply(i[0] ? 32'(`RMF_FN_BANDPASS) : 32'h0);
      chk(len_q, exp_len(auto_idx(i[1] ? 5000 : 100, i[0] ? 16 : 4)));
    end
    // Every function and filter code with random selection and steering
    for (int i = 0; i < 16; i++) begin
      f = i % 8;
      s = $urandom_range(7, 0);
      steer_freq_hz <= 20'($urandom_range(100000, 1));
      apply((32'h7 << 20) | (32'(s) << 12) | (32'(i % 3) << 8) | (32'(i % 4) << 4) | 32'(f));
      chk(weight_sel, (f < 4) ? 32'(s) : 32'h0);
      chk(bp_center_hz, exp_center(f, s, steer_freq_hz));
      chk(bp_bw_permille, (f == 4 || f == 5) ? 32'h34 : 32'h0);
      bus(1'b0, `RMF_OFS_STATUS, 32'h0);
      chk(rd[9:0], 32'((i % 3) << 8) | 32'((i % 4) << 4) | 32'(f));
      if (f == 5) chk(rd[14:12], `RMF_FSEL_NARROW);
    end
    report_and_stop;
  end
endmodule

// File: verif/rmf_stream_src.sv
// Sample stream source standing in for the analyzer input
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Stream source
// ----------------------------------------------------------------
module rmf_stream_src #(
  parameter DW = 24
) (
  input  wire                 clk,
  input  wire                 rstn,
  input  wire [1:0]           mode,
  output reg                  smp_valid,
  output reg  signed [DW-1:0] smp_a,
  output reg  signed [DW-1:0] smp_b
);
  reg [3:0] ph_q;
  reg       skip_q;

  // Square wave on A, 8 strobes a period, noisy level; B silent.
  // Mode 1 strobes every cycle, mode 2 every other. Idle lines toggle
  // so a stale value never passes for a sample.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_q      <= 4'h0;
      skip_q    <= 1'b0;
      smp_valid <= 1'b0;
      smp_a     <= '0;
      smp_b     <= '0;
    end else if (mode != 2'h0 && !(mode == 2'h2 && skip_q)) begin
      skip_q    <= 1'b1;
      ph_q      <= ph_q + 4'h1;
      smp_valid <= 1'b1;
      smp_a     <= ph_q[2] ? -DW'($urandom_range(4095, 2048)) :
                   DW'($urandom_range(4095, 2048));
      smp_b     <= '0;
    end else begin
      skip_q    <= 1'b0;
      smp_valid <= 1'b0;
      smp_a     <= ~smp_a;
      smp_b     <= ~smp_b;
    end
  end
endmodule

// File: verif/rmf_top_monitor.sv
// Port checker for the reading meter filter and detector block
`timescale 1ns/100ps
`include "rmf_defs.vh"
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module rmf_top_monitor #(
  parameter DW = 24,
  parameter FW = 20
) (
  input wire          hclk,
  input wire          hresetn,
  input wire          hsel,
  input wire [1:0]    htrans,
  input wire          hready,
  input wire [31:0]   hrdata,
  input wire          hreadyout,
  input wire          hresp,
  input wire          smp_valid,
  input wire [31:0]   res_a,
  input wire [31:0]   res_b,
  input wire          res_valid,
  input wire [1:0]    level_det_sel,
  input wire [2:0]    weight_sel,
  input wire [FW+2:0] bp_center_hz,
  input wire [15:0]   bp_bw_permille
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Bus side: slave never stalls and never errors
  okay_resp_a:
    assert property (hresp == 1'b0) else $error("hresp not OKAY");
  ready_up_a:
    assert property ($past(hresetn) |-> hreadyout) else $error("hreadyout low");
  // Read data only moves after an accepted address phase
  rdata_hold_a:
    assert property ($changed(hrdata) |-> $past(hsel && hready && htrans[1]))
    else $error("hrdata moved without a request");
  // Results only after a sample, and only with the strobe
  res_cause_a:
    assert property (res_valid |-> $past(smp_valid)) else $error("result without sample");
  res_hold_a:
    assert property ($changed({res_a, res_b}) |-> res_valid)
    else $error("results moved without strobe");
  // Settings reach the outputs only just after an interval ends
  settings_edge_a:
    assert property ($changed({level_det_sel, weight_sel, bp_bw_permille}) |->
                     ($past(res_valid) || $past(res_valid, 2)))
    else $error("settings moved mid interval");
  level_det_a:
    assert property (level_det_sel == 2'h0 || level_det_sel == 2'h1)
    else $error("level meter detector not rms");
  bw_value_a:
    assert property (bp_bw_permille == 16'h0 || bp_bw_permille == `RMF_BP_BW_PM)
    else $error("bandpass width wrong");
  center_bw_a:
    assert property (bp_center_hz != 0 |-> bp_bw_permille == `RMF_BP_BW_PM)
    else $error("center set outside bandpass");
  weight_bp_a:
    assert property (bp_bw_permille != 16'h0 |-> weight_sel == 3'h0)
    else $error("weighting chosen in bandpass");
endmodule

bind rmf_top rmf_top_monitor #(.DW(DW), .FW(FW)) rmf_top_monitor_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .smp_valid(smp_valid),
  .res_a(res_a), .res_b(res_b), .res_valid(res_valid), .level_det_sel(level_det_sel),
  .weight_sel(weight_sel), .bp_center_hz(bp_center_hz), .bp_bw_permille(bp_bw_permille));
